// *** epr_defs.svh ***
// Offsets, field positions, reset values and timing figures of the pulse regenerator
`ifndef EPR_DEFS_SVH
`define EPR_DEFS_SVH

// Register byte offsets
`define EPR_OFS_NUM 8'h00
`define EPR_OFS_DEN 8'h04
`define EPR_OFS_CTRL 8'h08
`define EPR_OFS_STATUS 8'h0c

// Widths
`define EPR_RATIO_W 19
`define EPR_ACC_W 24
`define EPR_PEND_W 8
`define EPR_RATE_W 8

// Ratio range
`define EPR_RATIO_MIN 19'h00001
`define EPR_RATIO_MAX 19'h40000

// Control fields
`define EPR_CTRL_INV_LSB 0
`define EPR_CTRL_LIMEN_BIT 2
`define EPR_CTRL_METHOD_BIT 3
`define EPR_CTRL_NETCYC_LSB 4

// Status fields
`define EPR_STAT_ERR_BIT 0
`define EPR_STAT_LIM_BIT 1
`define EPR_STAT_MODE_LSB 2
`define EPR_STAT_PEND_LSB 8

// Reset values
`define EPR_NUM_RST 19'h00001
`define EPR_DEN_RST 19'h00001
`define EPR_INV_RST 2'h0
`define EPR_NETCYC_RST 3'h1
`define EPR_NETCYC_FASTEST 3'h0

// Accumulator guard, keeps the remainder far from wrap
`define EPR_ACC_GUARD 24'sh400000

// Timing: clock rate and the top regenerated edge rate after times-4
`define EPR_CLK_MHZ 200
`define EPR_MAX_RATE_MPPS 4
`endif

// *** epr_host_model.sv ***
// Host-side quadrature counter that watches the regenerated pulses
`timescale 1ns/1ps
module epr_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Pulses from the regenerator
  input wire logic in_a,
  input wire logic in_b,
  // Clears the edge spacing record
  input wire logic clr,
  // Position count and tightest edge spacing seen
  output logic signed [31:0] count,
  output logic [15:0] min_gap
);
  logic [1:0] prev_r;
  logic [15:0] gap_r;
  logic [1:0] cur;
  logic [1:0] dir;

  // Gray position of the pair, A leading B counts up
  assign cur = {in_b, in_a ^ in_b};
  assign dir = cur - prev_r;

  // Count every single-phase edge; a jump of both phases is ambiguous and skipped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'sh0;
      prev_r <= 2'h0;
      gap_r <= 16'h0;
      min_gap <= 16'hffff;
    end else begin
      prev_r <= cur;
      if (dir == 2'h1) begin
        count <= count + 32'sh1;
      end else if (dir == 2'h3) begin
        count <= count - 32'sh1;
      end
      if (dir != 2'h0) begin
        gap_r <= 16'h1;
        if (!clr && gap_r < min_gap) begin
          min_gap <= gap_r;
        end
      end else if (gap_r != 16'hffff) begin
        gap_r <= gap_r + 16'h1;
      end
      if (clr) begin
        min_gap <= 16'hffff;
      end
    end
  end
endmodule : epr_host_model

// *** epr_pkg.sv ***
// Types shared by the pulse regenerator modules
`include "epr_defs.svh"
package epr_pkg;
  typedef enum logic [2:0] {
    EPR_OFF = 3'h1,
    EPR_PASS = 3'h2,
    EPR_REGEN = 3'h4
  } epr_mode_type;

  typedef struct packed {
    logic a_q;
    logic b_q;
    logic step;
    logic up;
  } epr_dec_type;

  typedef struct packed {
    logic [1:0] phase;
    logic a;
    logic b;
  } epr_enc_type;

  typedef struct packed {
    epr_mode_type mode;
    logic [`EPR_RATIO_W-1:0] num;
    logic [`EPR_RATIO_W-1:0] den;
    logic [1:0] inv_sel;
    logic lim_en;
    logic method;
    logic [2:0] netcyc;
    logic signed [`EPR_ACC_W-1:0] acc;
    logic signed [`EPR_PEND_W-1:0] pend;
    logic [`EPR_RATE_W-1:0] rate_cnt;
    logic emit;
    logic emit_up;
    logic lim_hit;
    logic err;
    logic out_a;
    logic out_b;
    logic out_z;
    logic [31:0] rdata;
  } epr_state_type;
endpackage : epr_pkg

// *** epr_pulse_regen.sv ***
// Pulse regenerator: scale movement divided into A/B quadrature for the host
`timescale 1ns/1ps
`include "epr_defs.svh"

// Contract
// - Report movement as A/B quadrature pulses
// - Division path passes the scale index through unchanged
// - Fastest network cycle forces regeneration off
// - Output counts equal numerator/denominator times input
// - Numerator and denominator accept 1 to 262144
// - Odd invert select inverts phase B when regenerating; pass-through ignores it
// - Scale position is always the source
// - Method 0 passes through, 1 rebuilds A/B
// - Output edge rate capped at 4 Mpps; pass-through outputs follow the scale edges uncapped
// - Limit check enable gates the error
// - Error raised when output limit detected
module epr_pulse_regen #(
  parameter int STEP_CYCLES = (`EPR_CLK_MHZ + `EPR_MAX_RATE_MPPS - 1) / `EPR_MAX_RATE_MPPS,
  parameter int PEND_MAX = 64
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Feedback scale phases
  input wire logic scale_a,
  input wire logic scale_b,
  input wire logic scale_z,
  // Pulses to the host controller
  output logic pulse_out_a,
  output logic pulse_out_b,
  output logic pulse_out_z,
  // Error flag
  output logic regen_limit_error
);
  localparam logic [`EPR_RATE_W-1:0] RATE_RELOAD = `EPR_RATE_W'(STEP_CYCLES - 1);
  localparam logic signed [`EPR_PEND_W-1:0] PEND_HI = `EPR_PEND_W'(PEND_MAX);
  localparam logic signed [`EPR_PEND_W-1:0] PEND_LO = `EPR_PEND_W'(-PEND_MAX);

  // Parameter sanity
  if (STEP_CYCLES < 1 || STEP_CYCLES > 256) begin : g_bad_step
    $error("STEP_CYCLES out of range");
  end
  if (PEND_MAX < 1 || PEND_MAX > 127) begin : g_bad_pend
    $error("PEND_MAX out of range");
  end

  epr_pkg::epr_state_type st, st_nxt;
  logic dec_step;
  logic dec_up;
  logic enc_a;
  logic enc_b;
  logic [`EPR_RATIO_W-1:0] wval;
  logic wval_ok;
  logic signed [`EPR_ACC_W-1:0] num_s;
  logic signed [`EPR_ACC_W-1:0] den_s;
  logic signed [`EPR_ACC_W-1:0] acc_v;
  logic signed [`EPR_PEND_W-1:0] pend_v;
  logic lim_v;
  epr_pkg::epr_mode_type mode_v;

  // Scale edges are the only source of regenerated counts
  epr_quad_dec u_dec (
    .mclk(mclk),
    .rstn(rstn),
    .in_a(scale_a),
    .in_b(scale_b),
    .step(dec_step),
    .up(dec_up)
  );

  // Rate-limited steps become the regenerated phases
  epr_quad_enc u_enc (
    .mclk(mclk),
    .rstn(rstn),
    .step(st.emit),
    .up(st.emit_up),
    .out_a(enc_a),
    .out_b(enc_b)
  );

  // Write data checked against the ratio range
  assign wval = reg_wdata[`EPR_RATIO_W-1:0];
  assign wval_ok = (reg_wdata[31:`EPR_RATIO_W] == '0) && (wval >= `EPR_RATIO_MIN)
    && (wval <= `EPR_RATIO_MAX);
  assign num_s = signed'({{(`EPR_ACC_W-`EPR_RATIO_W){1'b0}}, st.num});
  assign den_s = signed'({{(`EPR_ACC_W-`EPR_RATIO_W){1'b0}}, st.den});

  // Next state of the whole block
  always_comb begin
    st_nxt = st;
    acc_v = st.acc;
    pend_v = st.pend;
    lim_v = 1'b0;
    mode_v = epr_pkg::EPR_OFF;
    st_nxt.rdata = '0;
    st_nxt.emit = 1'b0;

    // Register writes; out-of-range ratio values are ignored
    if (reg_wr) begin
      case (reg_addr)
        `EPR_OFS_NUM: begin
          if (wval_ok) begin
            st_nxt.num = wval;
          end
        end
        `EPR_OFS_DEN: begin
          if (wval_ok) begin
            st_nxt.den = wval;
          end
        end
        `EPR_OFS_CTRL: begin
          st_nxt.inv_sel = reg_wdata[`EPR_CTRL_INV_LSB +: 2];
          st_nxt.lim_en = reg_wdata[`EPR_CTRL_LIMEN_BIT];
          st_nxt.method = reg_wdata[`EPR_CTRL_METHOD_BIT];
          st_nxt.netcyc = reg_wdata[`EPR_CTRL_NETCYC_LSB +: 3];
        end
        default: begin
        end
      endcase
    end

    // Mode follows the settings; the fastest cycle overrides everything
    if (st.netcyc == `EPR_NETCYC_FASTEST) begin
      mode_v = epr_pkg::EPR_OFF;
    end else if (st.method) begin
      mode_v = epr_pkg::EPR_REGEN;
    end else begin
      mode_v = epr_pkg::EPR_PASS;
    end
    st_nxt.mode = mode_v;

    // Each scale count adds the numerator (up) or subtracts it (down); the guard keeps the sum from wrapping
    if (st.mode == epr_pkg::EPR_REGEN && dec_step) begin
      if (st.acc > `EPR_ACC_GUARD || st.acc < -`EPR_ACC_GUARD) begin
        lim_v = 1'b1;
      end else if (dec_up) begin
        acc_v = st.acc + num_s;
      end else begin
        acc_v = st.acc - num_s;
      end
    end

    // One denominator drained per cycle; the remainder stays in the sum
    if (st.acc >= den_s) begin
      if (st.pend < PEND_HI) begin
        acc_v = acc_v - den_s;
        pend_v = pend_v + 1'b1;
      end else begin
        lim_v = 1'b1;
      end
    end else if (st.acc <= -den_s) begin
      if (st.pend > PEND_LO) begin
        acc_v = acc_v + den_s;
        pend_v = pend_v - 1'b1;
      end else begin
        lim_v = 1'b1;
      end
    end

    // Edges leave no faster than the rate cap; backlog waits in pend
    if (st.rate_cnt != '0) begin
      st_nxt.rate_cnt = st.rate_cnt - 1'b1;
    end else if (st.pend != '0) begin
      st_nxt.emit = 1'b1;
      st_nxt.emit_up = ~st.pend[`EPR_PEND_W-1];
      st_nxt.rate_cnt = RATE_RELOAD;
      pend_v = st.pend[`EPR_PEND_W-1] ? pend_v + 1'b1 : pend_v - 1'b1;
    end
    st_nxt.acc = acc_v;
    st_nxt.pend = pend_v;

    // A mode change starts from a clean remainder and backlog
    if (mode_v != st.mode || st.mode != epr_pkg::EPR_REGEN) begin
      st_nxt.acc = '0;
      st_nxt.pend = '0;
      st_nxt.rate_cnt = '0;
      st_nxt.emit = 1'b0;
      lim_v = 1'b0;
    end

    // Sticky error: limit sets it only when enabled, set beats clear
    st_nxt.lim_hit = lim_v;
    if (reg_wr && reg_addr == `EPR_OFS_STATUS && reg_wdata[`EPR_STAT_ERR_BIT]) begin
      st_nxt.err = 1'b0;
    end
    if (lim_v && st.lim_en) begin
      st_nxt.err = 1'b1;
    end

    // Output select; the division path carries the scale index unchanged
    case (st.mode)
      epr_pkg::EPR_PASS: begin
        st_nxt.out_a = scale_a;
        st_nxt.out_b = scale_b;
        st_nxt.out_z = scale_z;
      end
      epr_pkg::EPR_REGEN: begin
        st_nxt.out_a = enc_a;
        st_nxt.out_b = enc_b ^ st.inv_sel[0];
        st_nxt.out_z = scale_z;
      end
      default: begin
        st_nxt.out_a = 1'b0;
        st_nxt.out_b = 1'b0;
        st_nxt.out_z = 1'b0;
      end
    endcase

    // Read data stands in the cycle after the strobe only
    if (reg_rd) begin
      case (reg_addr)
        `EPR_OFS_NUM: st_nxt.rdata = {{(32-`EPR_RATIO_W){1'b0}}, st.num};
        `EPR_OFS_DEN: st_nxt.rdata = {{(32-`EPR_RATIO_W){1'b0}}, st.den};
        `EPR_OFS_CTRL: begin
          st_nxt.rdata[`EPR_CTRL_INV_LSB +: 2] = st.inv_sel;
          st_nxt.rdata[`EPR_CTRL_LIMEN_BIT] = st.lim_en;
          st_nxt.rdata[`EPR_CTRL_METHOD_BIT] = st.method;
          st_nxt.rdata[`EPR_CTRL_NETCYC_LSB +: 3] = st.netcyc;
        end
        `EPR_OFS_STATUS: begin
          st_nxt.rdata[`EPR_STAT_ERR_BIT] = st.err;
          st_nxt.rdata[`EPR_STAT_LIM_BIT] = st.lim_hit;
          st_nxt.rdata[`EPR_STAT_MODE_LSB +: 3] = st.mode;
          st_nxt.rdata[`EPR_STAT_PEND_LSB +: `EPR_PEND_W] = st.pend;
        end
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // State register; reset leaves regeneration off with a 1/1 ratio
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.mode <= epr_pkg::EPR_OFF;
      st.num <= `EPR_NUM_RST;
      st.den <= `EPR_DEN_RST;
      st.inv_sel <= `EPR_INV_RST;
      st.netcyc <= `EPR_NETCYC_RST;
    end else begin
      st <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = st.rdata;
  assign pulse_out_a = st.out_a;
  assign pulse_out_b = st.out_b;
  assign pulse_out_z = st.out_z;
  assign regen_limit_error = st.err;

  // Helper: cycles since the last emitted edge, saturating
  logic [8:0] gap_cnt;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gap_cnt <= 9'h1ff;
    end else if (st.emit) begin
      gap_cnt <= 9'h000;
    end else if (gap_cnt != 9'h1ff) begin
      gap_cnt <= gap_cnt + 9'h001;
    end
  end

  AST_OFF_FORCED: assert property (@(posedge mclk) disable iff (!rstn)
    (st.netcyc == `EPR_NETCYC_FASTEST) && ($past(st.netcyc) == `EPR_NETCYC_FASTEST)
    |=> (st.mode == epr_pkg::EPR_OFF) ##1 (!pulse_out_a && !pulse_out_b && !pulse_out_z))
    else $error("regeneration not forced off");

  AST_RATIO_RANGE: assert property (@(posedge mclk) disable iff (!rstn)
    (st.num >= `EPR_RATIO_MIN) && (st.num <= `EPR_RATIO_MAX)
    && (st.den >= `EPR_RATIO_MIN) && (st.den <= `EPR_RATIO_MAX))
    else $error("ratio setting out of range");

  AST_RATE_CAP: assert property (@(posedge mclk) disable iff (!rstn)
    st.emit |-> (gap_cnt >= 9'(STEP_CYCLES - 1)))
    else $error("edges closer than rate cap");

  AST_ERR_GATED: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(st.err) |-> $past(st.lim_en) && st.lim_hit)
    else $error("error raised while check disabled");

  AST_ERR_ON_LIMIT: assert property (@(posedge mclk) disable iff (!rstn)
    (st.lim_hit && $past(st.lim_en)) |-> st.err)
    else $error("limit seen but error not raised");

  AST_PASS_DIRECT: assert property (@(posedge mclk) disable iff (!rstn)
    (st.mode == epr_pkg::EPR_PASS) |=> (pulse_out_a == $past(scale_a))
    && (pulse_out_b == $past(scale_b)) && (pulse_out_z == $past(scale_z)))
    else $error("pass-through mismatch");

  AST_REGEN_Z: assert property (@(posedge mclk) disable iff (!rstn)
    (st.mode == epr_pkg::EPR_REGEN) |=> (pulse_out_z == $past(scale_z)) && (pulse_out_a == $past(enc_a)))
    else $error("index disturbed by division path");

  AST_B_INVERT: assert property (@(posedge mclk) disable iff (!rstn)
    (st.mode == epr_pkg::EPR_REGEN) |=> (pulse_out_b == ($past(enc_b) ^ $past(st.inv_sel[0]))))
    else $error("phase B logic wrong");

  AST_REMAINDER_KEPT: assert property (@(posedge mclk) disable iff (!rstn)
    (st.mode == epr_pkg::EPR_REGEN) && $stable(st.mode) && (mode_v == epr_pkg::EPR_REGEN) && !dec_step
    && (st.acc < den_s) && (st.acc > -den_s) && !reg_wr |=> $stable(st.acc))
    else $error("remainder lost");

  AST_RATIO_STEP: assert property (@(posedge mclk) disable iff (!rstn)
    (st.mode == epr_pkg::EPR_REGEN) && (mode_v == epr_pkg::EPR_REGEN) && dec_step && dec_up
    && (st.acc == '0) && (st.pend == '0) && (st.num >= st.den) && !reg_wr
    |-> ##2 ((st.pend != '0) || st.emit))
    else $error("count not carried to output");

  COV_EMIT: cover property (@(posedge mclk) disable iff (!rstn) st.emit ##[1:300] st.emit);
  COV_ERR: cover property (@(posedge mclk) disable iff (!rstn) $rose(st.err));
  COV_PASS: cover property (@(posedge mclk) disable iff (!rstn) st.mode == epr_pkg::EPR_PASS);
  COV_OFF: cover property (@(posedge mclk) disable iff (!rstn)
    (st.mode == epr_pkg::EPR_REGEN) ##1 (st.mode == epr_pkg::EPR_OFF));
endmodule : epr_pulse_regen

// *** epr_quad_dec.sv ***
// Times-4 quadrature decoder: one step pulse per valid scale edge
`timescale 1ns/1ps
module epr_quad_dec (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Scale phases
  input wire logic in_a,
  input wire logic in_b,
  // Decoded count
  output logic step,
  output logic up
);
  epr_pkg::epr_dec_type st, st_nxt;

  // Edge of either phase is one count; both changing at once is dropped
  always_comb begin
    st_nxt = st;
    st_nxt.a_q = in_a;
    st_nxt.b_q = in_b;
    st_nxt.step = (in_a ^ st.a_q) ^ (in_b ^ st.b_q);
    // A edge: up when A now differs from B; B edge: up when B now equals A
    st_nxt.up = (in_a ^ st.a_q) ? (in_a ^ st.b_q) : ~(in_b ^ st.a_q);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

  assign step = st.step;
  assign up = st.up;
endmodule : epr_quad_dec

// *** epr_quad_enc.sv ***
// Quadrature encoder: one output edge per step pulse, A leads B when counting up
`timescale 1ns/1ps
module epr_quad_enc (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Step request
  input wire logic step,
  input wire logic up,
  // Phases
  output logic out_a,
  output logic out_b
);
  epr_pkg::epr_enc_type st, st_nxt;

  // Phase walks 00,10,11,01 upward; gray order keeps one edge per step
  always_comb begin
    st_nxt = st;
    if (step) begin
      st_nxt.phase = up ? st.phase + 2'h1 : st.phase - 2'h1;
    end
    st_nxt.a = st_nxt.phase[0] ^ st_nxt.phase[1];
    st_nxt.b = st_nxt.phase[1];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

  assign out_a = st.a;
  assign out_b = st.b;
endmodule : epr_quad_enc

// *** epr_tb.sv ***
// Self-checking bench for the pulse regenerator
`timescale 1ns/1ps
`include "epr_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb;
  localparam int STEP = 4;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic scale_a = 1'b0;
  logic scale_b = 1'b0;
  logic scale_z = 1'b0;
  logic pulse_out_a, pulse_out_b, pulse_out_z;
  logic regen_limit_error;
  logic host_clr = 1'b0;
  logic signed [31:0] host_count;
  logic [15:0] host_gap;
  logic signed [31:0] snap;
  logic [31:0] d;
  logic [1:0] pos = 2'h0;
  int miscompares = 0;
  int n_tests = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  epr_pulse_regen #(.STEP_CYCLES(STEP), .PEND_MAX(8)) uut (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scale_a(scale_a), .scale_b(scale_b),
    .scale_z(scale_z), .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b),
    .pulse_out_z(pulse_out_z), .regen_limit_error(regen_limit_error)
  );

  epr_host_model host (
    .mclk(mclk), .rstn(rstn), .in_a(pulse_out_a), .in_b(pulse_out_b), .clr(host_clr),
    .count(host_count), .min_gap(host_gap)
  );

  // Register write, one strobe cycle then one idle cycle
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  // Register read; data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    data = reg_rdata;
    @(posedge mclk);
  endtask : rd

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    rd(addr, d);
    `CHK(d, exp)
  endtask : rd_chk

  // Scale movement as clean quadrature, one phase edge per step
  task automatic move(input int n, input bit up, input int gap);
    repeat (n) begin
      pos = up ? pos + 2'h1 : pos - 2'h1;
      scale_a <= pos[0] ^ pos[1];
      scale_b <= pos[1];
      repeat (gap) @(posedge mclk);
    end
  endtask : move

  // Let the backlog drain, then compare the host's count change
  task automatic expect_delta(input int n);
    repeat (80) @(posedge mclk);
    `CHK(host_count - snap, 32'(n))
    snap = host_count;
  endtask : expect_delta

  task automatic settle();
    repeat (20) @(posedge mclk);
    snap = host_count;
  endtask : settle

  task automatic test_done(input string name);
    $display("test %s finished", name);
  endtask : test_done

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Watchdog: the tests need a few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd_chk(`EPR_OFS_NUM, 32'h1);
    rd_chk(`EPR_OFS_DEN, 32'h1);
    rd_chk(`EPR_OFS_CTRL, 32'h10);
    rd(`EPR_OFS_STATUS, d);
    `CHK(d[4:2], 3'(epr_pkg::EPR_PASS))
    rd_chk(8'h10, 32'h0);
    test_done("reset values");
    // Pass-through ignores the B invert select
    wr(`EPR_OFS_CTRL, 32'h11);
    for (int i = 0; i < 8; i++) begin
      {scale_a, scale_b, scale_z} <= i[2:0];
      @(posedge mclk);
      #1;
      `CHK({pulse_out_a, pulse_out_b, pulse_out_z}, i[2:0])
      @(posedge mclk);
    end
    test_done("pass through");
    wr(`EPR_OFS_CTRL, 32'h09);
    repeat (2) @(posedge mclk);
    #1;
    `CHK({pulse_out_a, pulse_out_b, pulse_out_z}, 3'h0)
    @(posedge mclk);
    rd(`EPR_OFS_STATUS, d);
    `CHK(d[4:2], 3'(epr_pkg::EPR_OFF))
    {scale_a, scale_b, scale_z} <= 3'h0;
    pos = 2'h0;
    settle();
    move(8, 1'b1, 8);
    expect_delta(0);
    test_done("fastest cycle off");
    // Out-of-range ratio writes are dropped
    wr(`EPR_OFS_NUM, 32'h0);
    wr(`EPR_OFS_DEN, 32'h0);
    wr(`EPR_OFS_NUM, 32'h40001);
    rd_chk(`EPR_OFS_NUM, 32'h1);
    rd_chk(`EPR_OFS_DEN, 32'h1);
    wr(`EPR_OFS_NUM, 32'h40000);
    rd_chk(`EPR_OFS_NUM, 32'h40000);
    wr(`EPR_OFS_NUM, 32'h3);
    wr(`EPR_OFS_DEN, 32'h4);
    wr(`EPR_OFS_CTRL, 32'h18);
    settle();
    rd(`EPR_OFS_STATUS, d);
    `CHK(d[4:2], 3'(epr_pkg::EPR_REGEN))
    scale_z <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(pulse_out_z, 1'b1)
    scale_z <= 1'b0;
    @(posedge mclk);
    move(40, 1'b1, 8);
    expect_delta(30);
    move(16, 1'b1, 8);
    expect_delta(12);
    move(8, 1'b0, 8);
    expect_delta(-6);
    test_done("ratio");
    // Odd invert selects reverse the counted direction
    wr(`EPR_OFS_NUM, 32'h1);
    wr(`EPR_OFS_DEN, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(`EPR_OFS_CTRL, 32'h18 | 32'(s));
      settle();
      move(4, 1'b1, 8);
      expect_delta(s[0] ? -4 : 4);
    end
    test_done("b invert");
    // Overrun without and with the limit check
    wr(`EPR_OFS_CTRL, 32'h18);
    settle();
    host_clr <= 1'b1;
    @(posedge mclk);
    host_clr <= 1'b0;
    move(30, 1'b1, 1);
    repeat (80) @(posedge mclk);
    `CHK(regen_limit_error, 1'b0)
    `CHK(host_gap >= 16'(STEP), 1'b1)
    `CHK((host_count - snap) < 32'sd30, 1'b1)
    wr(`EPR_OFS_CTRL, 32'h1c);
    move(30, 1'b1, STEP);
    repeat (80) @(posedge mclk);
    `CHK(regen_limit_error, 1'b0)
    move(30, 1'b1, 1);
    repeat (80) @(posedge mclk);
    `CHK(regen_limit_error, 1'b1)
    rd(`EPR_OFS_STATUS, d);
    `CHK(d[0], 1'b1)
    wr(`EPR_OFS_STATUS, 32'h1);
    #1;
    `CHK(regen_limit_error, 1'b0)
    @(posedge mclk);
    test_done("limit error");
    end_sim();
  end
endmodule : tb
